// file: scmc_pkg.sv
// Constants and types shared by the clock and operating mode controller.
// Assumes a 20 MHz APB clock and byte addresses on an 8-bit paddr.
package scmc_pkg;

  // Bus geometry
  localparam int SCMC_ADDR_W = 8;
  localparam int SCMC_DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] SCMC_MODE_OFS = 8'h00;
  localparam logic [7:0] SCMC_CTRL_OFS = 8'h04;
  localparam logic [7:0] SCMC_TIME_BASE_OFS = 8'h08;
  localparam logic [7:0] SCMC_PIN_OFS = 8'h0C;
  localparam logic [7:0] SCMC_STAT_OFS = 8'h10;

  // Mode register fields
  localparam int SCMC_DIV_LSB = 5;
  localparam int SCMC_FAST_WAKE_BIT = 4;
  localparam int SCMC_SLOW_RDY_BIT = 3;
  localparam int SCMC_FAST_RDY_BIT = 2;
  localparam int SCMC_IDLE_EN_BIT = 1;
  localparam int SCMC_FAST_SEL_BIT = 0;
  // Control, time base, pin share and status fields
  localparam int SCMC_KEEP_ON_BIT = 7;
  localparam int SCMC_LOW_POWER_BIT = 0;
  localparam int SCMC_PIN_OSC_BIT = 0;
  localparam int SCMC_STAT_WAKING_BIT = 4;
  localparam int SCMC_STAT_SEL_LSB = 5;

  // Reset values
  localparam logic [2:0] SCMC_DIV_RST = 3'h0;
  localparam logic SCMC_FAST_WAKE_RST = 1'b0;
  localparam logic SCMC_IDLE_EN_RST = 1'b1;
  localparam logic SCMC_FAST_SEL_RST = 1'b1;
  localparam logic SCMC_KEEP_ON_RST = 1'b0;
  localparam logic SCMC_LOW_POWER_RST = 1'b0;
  localparam logic SCMC_PIN_OSC_RST = 1'b0;

  // Divider codes: below this code the substitute clock is chosen
  localparam logic [2:0] SCMC_DIV_FIRST = 3'h2;

  // Start-up counts, in cycles of the oscillator concerned
  localparam int SCMC_CNT_W = 10;
  localparam logic [9:0] SCMC_FAST_XTAL_START = 10'h080;
  localparam logic [9:0] SCMC_FAST_RC_START = 10'h010;
  localparam logic [9:0] SCMC_SLOW_XTAL_START = 10'h080;
  localparam logic [1:0] SCMC_SLOW_RC_START = 2'h2;
  // Cycles of suppressed system ticks after a source switch
  localparam logic [1:0] SCMC_SWITCH_GAP = 2'h2;

  // Operating modes, Gray coded along run, idle, sleep
  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_HALT_SYSCLK_ON = 3'h1,
    MODE_HALT_SYSCLK_OFF = 3'h3,
    MODE_HALT_SUBCLK_ON = 3'h2,
    MODE_HALT_ALL_OFF = 3'h6
  } scmc_mode_t;

  // System clock source in use
  typedef enum logic [1:0] {
    SEL_FAST = 2'h0,
    SEL_DIV = 2'h1,
    SEL_SUB = 2'h3
  } scmc_sel_t;

endpackage

// file: scmc_fast_div.sv
// Divider of the fast clock tick stream, ratios 2 to 64.
// Assumes fast_tick is a one-cycle pulse on clk, one per fast period.
`timescale 1ns/1ps
module scmc_fast_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fast_tick,
  input wire logic [2:0] div_code,
  output logic div_tick
);
  import scmc_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic [2:0] code;
    logic tick;
  } scmc_div_st_t;

  scmc_div_st_t st_q;
  scmc_div_st_t st_d;
  logic [5:0] mask;

  // Terminal count mask for the ratio in force
  assign mask = (st_q.code < SCMC_DIV_FIRST) ? 6'h3F :
                (6'h3F >> (st_q.code - SCMC_DIV_FIRST));

  // Count fast ticks; a new ratio is taken only at a period end
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (fast_tick) begin
      st_d.cnt = st_q.cnt + 6'h01;
      if ((st_q.cnt & mask) == mask) begin
        st_d.tick = 1'b1;
        st_d.cnt = 6'h00;
        st_d.code = div_code; // Avoids a short period on a ratio change
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign div_tick = st_q.tick;
endmodule

// file: scmc_ctrl.sv
// Clock source selection and operating mode gating, APB register slave.
// Clocks leave as one-cycle enable pulses on pclk; oscillators outside.
// Notes on behaviour
// - fast RC frequency fixed by strap
// - pin share bit frees crystal pins
// - power bit 0 quick, 1 low power
// - power bit clears at reset
// - crystal runs when used outside full sleep, low power starts slower
// - source from select bit and divider field
// - run mode fast clock divided one to 64
// - fast source crystal or RC by strap
// - substitute and time base sources by strap
// - fast oscillator stops on substitute clock
// - five modes gate CPU and clocks
// - run mode uses a fast oscillator
// - slow run uses substitute, fast off
// - substitute clocks CPU during fast wake
// - slow oscillators clock time base independently
// - slow crystal unusable until start-up done
// - field codes select substitute or division
// - select bit high gives undivided fast
// - halt picks sleep or idle mode
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module scmc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scmc_pkg::SCMC_ADDR_W-1:0] paddr,
  input wire logic [scmc_pkg::SCMC_DATA_W-1:0] pwdata,
  output logic [scmc_pkg::SCMC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_fast_crystal,
  input wire logic int_fast_rc,
  input wire logic ext_slow_crystal,
  input wire logic int_slow_rc,
  input wire logic cfg_fast_is_rc,
  input wire logic cfg_sub_is_rc,
  input wire logic cfg_time_base_is_rc,
  input wire logic [1:0] cfg_fast_rc_freq,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enable,
  output logic cpu_clk_en,
  output logic system_clock_out,
  output logic substitute_clock,
  output logic time_base_clock,
  output logic fast_clock,
  output logic ext_fast_crystal_en,
  output logic int_fast_rc_en,
  output logic [1:0] int_fast_rc_freq,
  output logic ext_slow_crystal_en,
  output logic int_slow_rc_en,
  output logic slow_crystal_low_power,
  output logic slow_crystal_pins_osc,
  output logic [2:0] op_mode
);
  import scmc_pkg::*;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic cfg_done;
    logic fast_rc;
    logic sub_rc;
    logic tb_rc;
    logic [1:0] rc_freq;
    logic [2:0] div;
    logic fast_wake;
    logic idle_en;
    logic fast_sel;
    logic keep_on;
    logic low_power;
    logic pin_osc;
    scmc_mode_t mode;
    scmc_sel_t cur_sel;
    logic [1:0] hold;
    logic waking;
    logic [9:0] fast_cnt;
    logic fast_rdy;
    logic [9:0] xtal_cnt;
    logic xtal_rdy;
    logic [1:0] lrc_cnt;
    logic lrc_rdy;
    logic [31:0] rdata;
    logic [4:0] ticks;
  } scmc_ctl_st_t;

  scmc_ctl_st_t st_q;
  scmc_ctl_st_t st_d;

  logic [3:0] rise;
  logic fast_raw;
  logic fast_ok;
  logic div_tick;
  logic sub_tick;
  logic tb_tick;
  logic src_tick;
  logic sys_tick;
  logic old_tick;
  logic fast_on;
  logic xtal_used;
  logic slow_on;
  logic slow_rdy;
  logic [9:0] xtal_limit;
  logic [9:0] fast_limit;
  scmc_sel_t target;
  logic wr_take;
  logic rd_setup;
  logic addr_hit;
  logic [31:0] rd_mux;

  // Oscillator edges, taken only from the second sync stage
  assign rise = st_q.sync2 & ~st_q.prev;

  assign fast_raw = st_q.fast_rc ? rise[1] : rise[0];
  assign fast_ok = fast_raw & st_q.fast_rdy;

  scmc_fast_div u_div (
    .clk(pclk),
    .rst_n(presetn),
    .fast_tick(fast_ok),
    .div_code(st_q.div),
    .div_tick(div_tick)
  );

  // substitute and time base sources by strap
  assign sub_tick = st_q.sub_rc ? (rise[3] & st_q.lrc_rdy)
                                : (rise[2] & st_q.xtal_rdy);
  assign tb_tick = st_q.tb_rc ? (rise[3] & st_q.lrc_rdy)
                              : (rise[2] & st_q.xtal_rdy);
  assign slow_rdy = st_q.sub_rc ? st_q.lrc_rdy : st_q.xtal_rdy;

  // source from select bit and field
  assign target = st_q.fast_sel ? SEL_FAST :
                  (st_q.div < SCMC_DIV_FIRST) ? SEL_SUB : SEL_DIV;

  // Tick of the source currently driving the system clock
  always_comb begin
    unique case (st_q.cur_sel)
      SEL_FAST: src_tick = fast_ok;
      SEL_DIV: src_tick = div_tick;
      SEL_SUB: src_tick = sub_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // switch only at an old period end
  // A stopped fast source has no period to finish, so it may not stall
  assign old_tick = src_tick |
                    ((st_q.cur_sel != SEL_SUB) & ~st_q.fast_rdy);

  // new source may not tick right after the old one
  // Costs at most one lengthened period per switch
  assign sys_tick = src_tick & (st_q.hold == 2'h0);

  assign fast_on = ((st_q.mode == MODE_RUN) ||
                    (st_q.mode == MODE_HALT_SYSCLK_ON)) &&
                   ((st_q.cur_sel != SEL_SUB) || (target != SEL_SUB));

  // slow oscillators in use run outside full sleep
  assign xtal_used = ~st_q.sub_rc | ~st_q.tb_rc;
  assign slow_on = st_q.mode != MODE_HALT_ALL_OFF;

  assign xtal_limit = st_q.low_power ? (SCMC_SLOW_XTAL_START << 1)
                                     : SCMC_SLOW_XTAL_START;
  assign fast_limit = st_q.fast_rc ? SCMC_FAST_RC_START
                                   : SCMC_FAST_XTAL_START;

  // APB decode; no wait states, read data latched in the setup cycle
  assign wr_take = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign addr_hit = (paddr == SCMC_MODE_OFS) ||
                    (paddr == SCMC_CTRL_OFS) ||
                    (paddr == SCMC_TIME_BASE_OFS) ||
                    (paddr == SCMC_PIN_OFS) ||
                    (paddr == SCMC_STAT_OFS);

  // Read data; unmapped offsets and unused bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      SCMC_MODE_OFS: begin
        rd_mux[SCMC_DIV_LSB +: 3] = st_q.div;
        rd_mux[SCMC_FAST_WAKE_BIT] = st_q.fast_wake;
        rd_mux[SCMC_SLOW_RDY_BIT] = slow_rdy;
        rd_mux[SCMC_FAST_RDY_BIT] = st_q.fast_rdy;
        rd_mux[SCMC_IDLE_EN_BIT] = st_q.idle_en;
        rd_mux[SCMC_FAST_SEL_BIT] = st_q.fast_sel;
      end
      SCMC_CTRL_OFS: rd_mux[SCMC_KEEP_ON_BIT] = st_q.keep_on;
      SCMC_TIME_BASE_OFS: rd_mux[SCMC_LOW_POWER_BIT] = st_q.low_power;
      SCMC_PIN_OFS: rd_mux[SCMC_PIN_OSC_BIT] = st_q.pin_osc;
      SCMC_STAT_OFS: begin
        rd_mux[2:0] = st_q.mode;
        rd_mux[SCMC_STAT_WAKING_BIT] = st_q.waking;
        rd_mux[SCMC_STAT_SEL_LSB +: 2] = st_q.cur_sel;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Next state of the whole controller
  always_comb begin
    st_d = st_q;
    st_d.sync1 = {int_slow_rc, ext_slow_crystal, int_fast_rc,
                  ext_fast_crystal};
    st_d.sync2 = st_q.sync1;
    st_d.prev = st_q.sync2;

    if (!st_q.cfg_done) begin
      st_d.cfg_done = 1'b1;
      st_d.fast_rc = cfg_fast_is_rc;
      st_d.sub_rc = cfg_sub_is_rc;
      st_d.tb_rc = cfg_time_base_is_rc;
      st_d.rc_freq = cfg_fast_rc_freq;
    end

    if (rd_setup) begin
      st_d.rdata = rd_mux;
    end

    // Register writes take effect in the access cycle
    if (wr_take) begin
      unique case (paddr)
        SCMC_MODE_OFS: begin
          st_d.div = pwdata[SCMC_DIV_LSB +: 3];
          st_d.fast_wake = pwdata[SCMC_FAST_WAKE_BIT];
          st_d.idle_en = pwdata[SCMC_IDLE_EN_BIT];
          st_d.fast_sel = pwdata[SCMC_FAST_SEL_BIT];
        end
        SCMC_CTRL_OFS: st_d.keep_on = pwdata[SCMC_KEEP_ON_BIT];
        SCMC_TIME_BASE_OFS: st_d.low_power = pwdata[SCMC_LOW_POWER_BIT];
        SCMC_PIN_OFS: st_d.pin_osc = pwdata[SCMC_PIN_OSC_BIT];
        default: st_d.rdata = st_q.rdata;
      endcase
    end

    if (!fast_on) begin
      st_d.fast_cnt = 10'h000;
      st_d.fast_rdy = 1'b0;
    end else if (fast_raw && !st_q.fast_rdy) begin
      st_d.fast_cnt = st_q.fast_cnt + 10'h001;
      if (st_q.fast_cnt + 10'h001 >= fast_limit) begin
        st_d.fast_rdy = 1'b1;
      end
    end

    if (!(slow_on && xtal_used)) begin
      st_d.xtal_cnt = 10'h000;
      st_d.xtal_rdy = 1'b0;
    end else if (rise[2] && !st_q.xtal_rdy) begin
      st_d.xtal_cnt = st_q.xtal_cnt + 10'h001;
      if (st_q.xtal_cnt + 10'h001 >= xtal_limit) begin
        st_d.xtal_rdy = 1'b1;
      end
    end
    if (!(slow_on && !xtal_used) && !(slow_on && st_q.sub_rc) &&
        !(slow_on && st_q.tb_rc)) begin
      st_d.lrc_cnt = 2'h0;
      st_d.lrc_rdy = 1'b0;
    end else if (rise[3] && !st_q.lrc_rdy) begin
      st_d.lrc_cnt = st_q.lrc_cnt + 2'h1;
      if (st_q.lrc_cnt + 2'h1 >= SCMC_SLOW_RC_START) begin
        st_d.lrc_rdy = 1'b1;
      end
    end

    // adopt new source at a boundary
    if (st_q.hold != 2'h0) begin
      st_d.hold = st_q.hold - 2'h1;
    end
    if ((target != st_q.cur_sel) && old_tick) begin
      st_d.cur_sel = target;
      st_d.hold = SCMC_SWITCH_GAP;
    end

    unique case (st_q.mode)
      MODE_RUN: begin
        if (halt_req) begin
          if (st_q.idle_en) begin
            st_d.mode = st_q.keep_on ? MODE_HALT_SYSCLK_ON
                                     : MODE_HALT_SYSCLK_OFF;
          end else begin
            st_d.mode = wdt_enable ? MODE_HALT_SUBCLK_ON
                                   : MODE_HALT_ALL_OFF;
          end
        end
      end
      MODE_HALT_SYSCLK_ON, MODE_HALT_SYSCLK_OFF, MODE_HALT_SUBCLK_ON,
      MODE_HALT_ALL_OFF: begin
        if (wake_req) begin
          st_d.mode = MODE_RUN;
          st_d.waking = st_q.fast_wake & ~st_q.fast_rc &
                        (st_q.cur_sel != SEL_SUB) &
                        ((st_q.mode == MODE_HALT_SYSCLK_OFF) ||
                         (st_q.mode == MODE_HALT_SUBCLK_ON));
        end
      end
      default: st_d.mode = MODE_RUN;
    endcase
    if (st_q.waking && st_q.fast_rdy) begin
      st_d.waking = 1'b0;
      st_d.hold = SCMC_SWITCH_GAP; // Handover from substitute ticks
    end

    st_d.ticks = 5'h00;
    if (st_q.mode == MODE_RUN) begin
      st_d.ticks[0] = st_q.waking ? sub_tick : sys_tick;
    end
    if ((st_q.mode == MODE_RUN) || (st_q.mode == MODE_HALT_SYSCLK_ON)) begin
      st_d.ticks[1] = st_q.waking ? sub_tick : sys_tick;
    end
    st_d.ticks[2] = slow_on & sub_tick;
    // time base off only in sleep
    st_d.ticks[3] = tb_tick & (st_q.mode != MODE_HALT_ALL_OFF) &
                    (st_q.mode != MODE_HALT_SUBCLK_ON);
    st_d.ticks[4] = fast_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.div <= SCMC_DIV_RST;
      st_q.fast_wake <= SCMC_FAST_WAKE_RST;
      st_q.idle_en <= SCMC_IDLE_EN_RST;
      st_q.fast_sel <= SCMC_FAST_SEL_RST;
      st_q.keep_on <= SCMC_KEEP_ON_RST;
      st_q.low_power <= SCMC_LOW_POWER_RST;
      st_q.pin_osc <= SCMC_PIN_OSC_RST;
      st_q.mode <= MODE_RUN;
      st_q.cur_sel <= SEL_FAST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign cpu_clk_en = st_q.ticks[0];
  assign system_clock_out = st_q.ticks[1];
  assign substitute_clock = st_q.ticks[2];
  assign time_base_clock = st_q.ticks[3];
  assign fast_clock = st_q.ticks[4];
  assign ext_fast_crystal_en = fast_on & ~st_q.fast_rc;
  assign int_fast_rc_en = fast_on & st_q.fast_rc;
  assign int_fast_rc_freq = st_q.rc_freq;
  assign ext_slow_crystal_en = slow_on & xtal_used;
  assign int_slow_rc_en = slow_on & (st_q.sub_rc | st_q.tb_rc);
  assign slow_crystal_low_power = st_q.low_power;
  assign slow_crystal_pins_osc = st_q.pin_osc;
  assign op_mode = st_q.mode;
endmodule

// file: scmc_osc_model.sv
// Behavioural oscillator on the far side of the clock controller.
// Assumes the controller drives its enable; stopped output rests low.
`timescale 1ns/1ps
module scmc_osc_model #(
  parameter real HALF_NS = 250.0
) (
  input wire logic en,
  output logic osc
);
  // free running once enabled
  // A stopped oscillator shows no stale edges, so it parks low
  always begin
    if (en === 1'b1) begin
      #(HALF_NS) osc = ~osc;
    end else begin
      osc = 1'b0;
      @(en);
    end
  end
endmodule

// file: scmc_ctrl_chk.sv
// Port checker for the clock source and operating mode controller.
// Assumes one pclk domain and presetn as async active-low reset.
`timescale 1ns/1ps
module scmc_ctrl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scmc_pkg::SCMC_ADDR_W-1:0] paddr,
  input wire logic [scmc_pkg::SCMC_DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic [1:0] cfg_fast_rc_freq,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enable,
  input wire logic cpu_clk_en,
  input wire logic system_clock_out,
  input wire logic substitute_clock,
  input wire logic time_base_clock,
  input wire logic ext_fast_crystal_en,
  input wire logic int_fast_rc_en,
  input wire logic [1:0] int_fast_rc_freq,
  input wire logic slow_crystal_low_power,
  input wire logic slow_crystal_pins_osc,
  input wire logic [2:0] op_mode
);
  import scmc_pkg::*;
  logic idle_q, keep_q;
  logic [2:0] halt_exp;
  wire wr_acc = psel && penable && pwrite && pready;

  // Halt controls as software last wrote them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= SCMC_IDLE_EN_RST;
      keep_q <= SCMC_KEEP_ON_RST;
    end else if (wr_acc && paddr == SCMC_MODE_OFS) begin
      idle_q <= pwdata[SCMC_IDLE_EN_BIT];
    end else if (wr_acc && paddr == SCMC_CTRL_OFS) begin
      keep_q <= pwdata[SCMC_KEEP_ON_BIT];
    end
  end

  // Mode a halt should land in
  always_comb begin
    if (idle_q) begin
      halt_exp = keep_q ? MODE_HALT_SYSCLK_ON : MODE_HALT_SYSCLK_OFF;
    end else begin
      halt_exp = wdt_enable ? MODE_HALT_SUBCLK_ON : MODE_HALT_ALL_OFF;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_halt;
    op_mode == MODE_RUN && halt_req && !wake_req;
  endsequence
  sequence s_dark;
    $stable(op_mode) && op_mode inside {MODE_HALT_SYSCLK_OFF,
      MODE_HALT_SUBCLK_ON, MODE_HALT_ALL_OFF};
  endsequence

  property p_cpu;
    $stable(op_mode) && op_mode != MODE_RUN |-> !cpu_clk_en;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clock in halt");
  property p_sys;
    s_dark |-> !system_clock_out;
  endproperty
  a_sys: assert property (p_sys) else $error("system clock not gated");
  property p_sub;
    $stable(op_mode) && op_mode == MODE_HALT_ALL_OFF |-> !substitute_clock;
  endproperty
  a_sub: assert property (p_sub) else $error("substitute not gated");
  property p_tb;
    $stable(op_mode) && op_mode inside {MODE_HALT_SUBCLK_ON,
      MODE_HALT_ALL_OFF} |-> !time_base_clock;
  endproperty
  a_tb: assert property (p_tb) else $error("time base not gated");
  property p_fast;
    s_dark |-> !ext_fast_crystal_en && !int_fast_rc_en;
  endproperty
  a_fast: assert property (p_fast) else $error("fast osc left on");
  property p_halt;
    s_halt |=> op_mode == halt_exp;
  endproperty
  a_halt: assert property (p_halt) else $error("wrong halt mode");
  property p_wake;
    op_mode != MODE_RUN && wake_req |=> op_mode == MODE_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not taken");
  property p_lp;
    wr_acc && paddr == SCMC_TIME_BASE_OFS |=>
      slow_crystal_low_power == $past(pwdata[SCMC_LOW_POWER_BIT]);
  endproperty
  a_lp: assert property (p_lp) else $error("low power bit lost");
  property p_pin;
    wr_acc && paddr == SCMC_PIN_OFS |=>
      slow_crystal_pins_osc == $past(pwdata[SCMC_PIN_OSC_BIT]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin share bit lost");
  property p_freq;
    $rose(presetn) |-> ##2 int_fast_rc_freq == cfg_fast_rc_freq;
  endproperty
  a_freq: assert property (p_freq) else $error("rc freq not strap");
  property p_glitch;
    system_clock_out |=> !system_clock_out [*2];
  endproperty
  a_glitch: assert property (p_glitch) else $error("runt system tick");
endmodule

bind scmc_ctrl scmc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .cfg_fast_rc_freq, .halt_req,
  .wake_req, .wdt_enable, .cpu_clk_en, .system_clock_out,
  .substitute_clock, .time_base_clock, .ext_fast_crystal_en,
  .int_fast_rc_en, .int_fast_rc_freq, .slow_crystal_low_power,
  .slow_crystal_pins_osc, .op_mode);

// file: system_clock_mode_control_test.sv
// Self-checking bench of the clock source and mode controller.
// Assumes behavioural oscillators; APB master and halt events driven here.
`timescale 1ns/1ps
module system_clock_mode_control_test;
  import scmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic halt_req = 1'b0;
  logic wake_req = 1'b0;
  logic wdt_enable = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, cpu_clk_en, system_clock_out, substitute_clock;
  logic time_base_clock, fast_clock, fx_en, fr_en, sx_en, sr_en, e;
  logic fx, fr, sx, sr, slow_crystal_low_power, slow_crystal_pins_osc;
  logic [1:0] int_fast_rc_freq;
  logic [2:0] op_mode, msk, cb;
  logic [31:0] rs = 32'h39bf_24ad;
  scmc_mode_t em;
  int bad_count = 0;
  int checked = 0;
  int cnt[5];
  int r;
  wire [4:0] ticks = {cpu_clk_en, time_base_clock, substitute_clock,
    system_clock_out, fast_clock};

  // 20 MHz bus clock
  always #25 pclk = ~pclk;

  scmc_osc_model #(.HALF_NS(250.0)) u_fx (.en(fx_en), .osc(fx));
  scmc_osc_model #(.HALF_NS(200.0)) u_fr (.en(fr_en), .osc(fr));
  scmc_osc_model #(.HALF_NS(1000.0)) u_sx (.en(sx_en), .osc(sx));
  scmc_osc_model #(.HALF_NS(1100.0)) u_sr (.en(sr_en), .osc(sr));

  scmc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_fast_crystal(fx), .int_fast_rc(fr), .ext_slow_crystal(sx),
    .int_slow_rc(sr), .cfg_fast_is_rc(1'b0), .cfg_sub_is_rc(1'b1),
    .cfg_time_base_is_rc(1'b0), .cfg_fast_rc_freq(2'h2),
    .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable),
    .cpu_clk_en(cpu_clk_en), .system_clock_out(system_clock_out),
    .substitute_clock(substitute_clock), .time_base_clock(time_base_clock),
    .fast_clock(fast_clock), .ext_fast_crystal_en(fx_en),
    .int_fast_rc_en(fr_en), .int_fast_rc_freq(int_fast_rc_freq),
    .ext_slow_crystal_en(sx_en), .int_slow_rc_en(sr_en),
    .slow_crystal_low_power(slow_crystal_low_power),
    .slow_crystal_pins_osc(slow_crystal_pins_osc), .op_mode(op_mode));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic scmc_mode_t halt_to(input logic [2:0] c);
    if (c[0]) return c[1] ? MODE_HALT_SYSCLK_ON : MODE_HALT_SYSCLK_OFF;
    return c[2] ? MODE_HALT_SUBCLK_ON : MODE_HALT_ALL_OFF;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      check(0, 1, "no pready");
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Count each kind of tick over n cycles
  task automatic meas(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge pclk);
      foreach (cnt[k]) cnt[k] += int'(ticks[k] === 1'b1);
    end
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    check(32'(op_mode), 32'(MODE_RUN), "reset mode");
    check(slow_crystal_low_power, 0, "reset low power");
    check(int_fast_rc_freq, 2'h2, "rc freq strap");
    apb(0, SCMC_MODE_OFS, 0);
    check(q & 32'hFFFF_FFF3, 32'h0000_0003, "mode reset");
    apb(0, SCMC_CTRL_OFS, 0);
    check(q, 0, "ctrl reset");
    apb(0, SCMC_TIME_BASE_OFS, 0);
    check(q, 0, "time base reset");
    apb(0, SCMC_PIN_OFS, 0);
    check(q, 0, "pin reset");
    // Unmapped place is refused and reads zero
    rs = xs(rs);
    apb(1, 8'h40, rs);
    check(e, 1, "unmapped write err");
    apb(0, 8'h40, 0);
    check(q, 0, "unmapped read");
    check(e, 1, "unmapped read err");
    // software sets the power bit, random junk above it
    for (int v = 1; v >= 0; v--) begin
      rs = xs(rs);
      apb(1, SCMC_TIME_BASE_OFS, {rs[31:1], v[0]});
      check(slow_crystal_low_power, v[0], "low power pin");
      apb(0, SCMC_TIME_BASE_OFS, 0);
      check(q, v, "low power read");
    end
    apb(1, SCMC_PIN_OFS, 1);
    check(slow_crystal_pins_osc, 1, "pins to crystal");
    // Every source code: 8 stands for the undivided select
    for (int c = 8; c >= 0; c--) begin
      apb(1, SCMC_MODE_OFS, c == 8 ? 32'h3 : {24'h0, c[2:0], 5'h02});
      repeat (1000) @(posedge pclk);
      meas(2000);
      if (c >= 2) begin
        r = (c == 8) ? 1 : 1 << (8 - c);
        check(cnt[1] * r <= cnt[0] + r && cnt[1] * r + r >= cnt[0], 1,
              "divided rate");
      end else begin
        check(cnt[1] <= cnt[2] + 1 && cnt[1] + 1 >= cnt[2], 1,
              "substitute rate");
        check(fx_en, 0, "fast osc stopped");
        check(cnt[0], 0, "no fast ticks");
      end
      apb(0, SCMC_STAT_OFS, 0);
      check(q[SCMC_STAT_SEL_LSB +: 2], c == 8 ? 0 : (c >= 2 ? 1 : 3),
            "source in use");
      apb(0, SCMC_MODE_OFS, 0);
      check(q[SCMC_FAST_RDY_BIT], c >= 2, "fast ready flag");
    end
    apb(1, SCMC_MODE_OFS, 32'h0000_0003);
    repeat (1500) @(posedge pclk);
    // Every halt combination in a random order
    rs = xs(rs);
    msk = rs[2:0];
    for (int i = 0; i < 8; i++) begin
      cb = i[2:0] ^ msk;
      em = halt_to(cb);
      apb(1, SCMC_CTRL_OFS, {24'h0, cb[1], 7'h0});
      // Fast wake on: leaving halt_sysclk_off or halt_subclk_on starts on the substitute
      apb(1, SCMC_MODE_OFS, {27'h0, 1'b1, 2'h0, cb[0], 1'b1});
      wdt_enable <= cb[2];
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
      @(posedge pclk);
      check(32'(op_mode), 32'(em), "halt mode");
      meas(400);
      check(cnt[4], 0, "cpu gated");
      check(cnt[1] > 0, em == MODE_HALT_SYSCLK_ON, "sys gate");
      check(cnt[2] > 0, em != MODE_HALT_ALL_OFF, "sub gate");
      check(cnt[3] > 0, em inside {MODE_HALT_SYSCLK_ON,
            MODE_HALT_SYSCLK_OFF}, "time base gate");
      check({fr_en, sx_en, sr_en}, {1'b0, {2{em != MODE_HALT_ALL_OFF}}},
            "osc enables");
      apb(0, SCMC_STAT_OFS, 0);
      check(q, 32'(em), "status in halt");
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      @(posedge pclk);
      check(32'(op_mode), 32'(MODE_RUN), "woken");
      apb(0, SCMC_STAT_OFS, 0);
      check(q[SCMC_STAT_WAKING_BIT], em inside {MODE_HALT_SYSCLK_OFF,
            MODE_HALT_SUBCLK_ON}, "fast wake");
      // A full sleep stopped the slow crystal; its restart is long
      repeat (em == MODE_HALT_ALL_OFF ? 6000 : 1500) @(posedge pclk);
      meas(100);
      check(cnt[4] > 0, 1, "cpu runs");
    end
    tally_and_finish();
  end
endmodule
